// ==== shared/kbl_pkg.sv ====
// Shared constants and types of the keyboard serial link
package kbl_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int LINK_PERIOD_NS = 160; // Keyboard oscillator period
    localparam int CONT_CHK_MS    = 60;  // Longest gap between clock checks
    localparam int QTR_CYC_DEF    = 8;   // Link cycles per quarter bit
    localparam int SYNC_LAT       = 4;   // Cycles for a line edge to settle
    localparam int RST_HOLD       = 1024; // Core cycles the link reset lasts

    // ------------------------------------------------------------------
    // Frame layout
    // ------------------------------------------------------------------
    localparam logic [3:0] PAR_IDX  = 4'h9; // Parity bit position
    localparam logic [3:0] STOP_IDX = 4'hA; // Stop bit position
    localparam logic [3:0] LEG_LAST = 4'h8; // Last bit of a legacy frame
    localparam logic [3:0] DAT_LO   = 4'h1; // First data bit position
    localparam logic [3:0] DAT_HI   = 4'h8; // Last data bit position
    localparam logic [7:0] RESEND_BYTE = 8'hFE; // Resend request code

    // ------------------------------------------------------------------
    // Link sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_TX   = 3'b001,
        ST_RX   = 3'b010,
        ST_ACK  = 3'b011,
        ST_FERR = 3'b100
    } kbl_state_t;

endpackage : kbl_pkg

// ==== shared/kbl_line_if.sv ====
// Raw and filtered signal group between the top and its synchroniser
`timescale 1ns/1ns
interface kbl_line_if #(parameter int W = 1);
    logic [W-1:0] raw;  // Levels from another domain
    logic [W-1:0] sync; // Levels after filtering
    modport sync_mp (input raw, output sync);
    modport user_mp (output raw, input sync);
endinterface : kbl_line_if

// ==== design/kbl_sync.sv ====
// Three-stage synchroniser with agreement filter
`timescale 1ns/1ns
module kbl_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic        i_clk,
    input wire logic        i_rst,
    // Signal group
    kbl_line_if.sync_mp     lines
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] o;
    } kbl_sync_t;

    kbl_sync_t q;
    kbl_sync_t d;

    // Shift chain; output follows once stages two and three agree
    always_comb begin
        d    = q;
        d.s1 = lines.raw;
        d.s2 = q.s1;
        d.s3 = q.s2;
        d.o  = (q.s3 & ~(q.s2 ^ q.s3)) | (q.o & (q.s2 ^ q.s3));
    end

    // State register
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign lines.sync = q.o;

endmodule : kbl_sync

// ==== design/kbl_link.sv ====
// Keyboard-side serial link: frame sequencer and core handshake
`timescale 1ns/1ns
module kbl_link #(
    parameter int QTR_CYC      = kbl_pkg::QTR_CYC_DEF,
    parameter int CONT_CHK_CYC = kbl_pkg::CONT_CHK_MS * 1000000
                                 / kbl_pkg::LINK_PERIOD_NS
) (
    // Core clock and reset
    input  wire logic       i_ref_clk,
    input  wire logic       i_reset,
    // Keyboard oscillator
    input  wire logic       i_link_clk,
    // Byte to send
    input  wire logic       i_tx_valid,
    input  wire logic [7:0] i_tx_data,
    input  wire logic       i_legacy_mode,
    output logic            o_tx_ready,
    // Byte received
    output logic            o_rx_valid,
    output logic [7:0]      o_rx_data,
    // Clock line
    input  wire logic       i_kclk_in,
    output logic            o_kclk_out,
    output logic            o_kclk_oe,
    // Data line
    input  wire logic       i_kdata_in,
    output logic            o_kdata_out,
    output logic            o_kdata_oe
);

    // ------------------------------------------------------------------
    // Derived counts
    // ------------------------------------------------------------------
    localparam int BIT_CYC = 4 * QTR_CYC;
    localparam int CW      = $clog2(BIT_CYC);
    localparam int GW      = $clog2(CONT_CHK_CYC + 1);
    localparam int RW      = $clog2(kbl_pkg::RST_HOLD + 1);
    localparam logic [CW-1:0] C_Q1   = CW'(QTR_CYC);
    localparam logic [CW-1:0] C_Q3   = CW'(3 * QTR_CYC);
    localparam logic [CW-1:0] C_END  = CW'(BIT_CYC - 1);
    localparam logic [CW-1:0] C_SET  = CW'(kbl_pkg::SYNC_LAT);
    localparam logic [CW-1:0] C_ONE  = CW'(1);
    localparam logic [RW-1:0] C_RST  = RW'(kbl_pkg::RST_HOLD);

    // ------------------------------------------------------------------
    // State records
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       ready;
        logic [8:0] hold;     // {legacy, data} offered to the link
        logic       req_tgl;
        logic       ack_seen;
        logic       rx_seen;
        logic       rx_valid;
        logic [7:0] rx_data;
        logic [RW-1:0] rst_cnt; // Link reset stretch count
        logic       rst_hold; // Reset level sent to the link side
    } kbl_core_t;

    typedef struct packed {
        kbl_pkg::kbl_state_t st;
        logic [CW-1:0] cnt;
        logic [3:0]    bit_idx;
        logic [8:0]    sh;       // {parity, data}
        logic          pend;
        logic [8:0]    pend_word;
        logic          resend;
        logic          tx_resend;
        logic          tx_legacy;
        logic          ferr;
        logic          clk_oe;
        logic          dat_oe;
        logic          line_lo;
        logic          req_seen;
        logic          ack_tgl;
        logic          rx_tgl;
        logic [7:0]    rx_byte;
        logic [GW-1:0] gap;
    } kbl_lnk_t;

    kbl_core_t cq;
    kbl_core_t cd;
    kbl_lnk_t  lq;
    kbl_lnk_t  ld;

    // Odd parity bit for a byte
    function automatic logic odd_par(input logic [7:0] b);
        odd_par = ~^b;
    endfunction : odd_par

    // ------------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------------
    kbl_line_if #(.W(1)) rs_if ();
    kbl_line_if #(.W(3)) lk_if ();
    kbl_line_if #(.W(2)) cr_if ();

    logic link_rst;
    logic clk_s;
    logic dat_s;
    logic req_s;
    logic ack_s;
    logic rx_s;

    // Inputs of each group
    assign rs_if.raw = cq.rst_hold;
    assign lk_if.raw = {i_kclk_in, i_kdata_in, cq.req_tgl};
    assign cr_if.raw = {lq.ack_tgl, lq.rx_tgl};

    // Reset for the link domain; filter has no reset of its own
    kbl_sync #(.W(1)) u_rst_sync (
        .i_clk (i_link_clk),
        .i_rst (1'b0),
        .lines (rs_if.sync_mp)
    );

    // Line levels and request toggle into the link domain
    kbl_sync #(.W(3)) u_lnk_sync (
        .i_clk (i_link_clk),
        .i_rst (link_rst),
        .lines (lk_if.sync_mp)
    );

    // Answer toggles into the core domain
    kbl_sync #(.W(2)) u_core_sync (
        .i_clk (i_ref_clk),
        .i_rst (i_reset),
        .lines (cr_if.sync_mp)
    );

    // Filtered levels
    assign link_rst = rs_if.sync[0];
    assign clk_s    = lk_if.sync[2];
    assign dat_s    = lk_if.sync[1];
    assign req_s    = lk_if.sync[0];
    assign ack_s    = cr_if.sync[1];
    assign rx_s     = cr_if.sync[0];

    // ------------------------------------------------------------------
    // Core domain
    // ------------------------------------------------------------------
    // Offer bytes by toggle, collect answers by toggle
    always_comb begin
        cd          = cq;
        cd.rx_valid = 1'b0;
        // Short core reset stretched so the slow link clock sees it
        cd.rst_hold = (cq.rst_cnt != '0);
        cd.rst_cnt  = cd.rst_hold ? cq.rst_cnt - RW'(1) : cq.rst_cnt;
        if (cq.ready && i_tx_valid) begin
            cd.hold    = {i_legacy_mode, i_tx_data};
            cd.req_tgl = ~cq.req_tgl;
            cd.ready   = 1'b0;
        end
        if (ack_s != cq.ack_seen) begin
            cd.ack_seen = ack_s;
            cd.ready    = 1'b1;
        end
        if (rx_s != cq.rx_seen) begin
            cd.rx_seen  = rx_s;
            cd.rx_valid = 1'b1;
            cd.rx_data  = lq.rx_byte; // Held still while toggle crosses
        end
    end

    // Core register
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            cq          <= '0;
            cq.ready    <= 1'b1;
            cq.rst_cnt  <= C_RST;
            cq.rst_hold <= 1'b1;
        end else begin
            cq <= cd;
        end
    end

    // ------------------------------------------------------------------
    // Link domain
    // ------------------------------------------------------------------
    logic clk_lo_win;
    logic bit_end;
    logic chk_win;
    logic [3:0] last_idx;
    logic [8:0] load_w;

    // Bit phase decode
    assign clk_lo_win = (lq.cnt >= C_Q1) && (lq.cnt < C_Q3);
    assign bit_end    = (lq.cnt == C_END);
    assign chk_win    = (lq.cnt >= C_SET) && (lq.cnt < C_Q1);
    assign last_idx   = lq.tx_legacy ? kbl_pkg::LEG_LAST : kbl_pkg::STOP_IDX;
    assign load_w     = lq.resend ? {1'b0, kbl_pkg::RESEND_BYTE}
                                  : lq.pend_word;

    // Frame sequencer
    always_comb begin
        ld         = lq;
        ld.line_lo = 1'b0;
        ld.cnt     = bit_end ? '0 : lq.cnt + C_ONE;
        ld.clk_oe  = clk_lo_win;
        ld.gap     = '0;
        if (req_s != lq.req_seen) begin
            ld.req_seen  = req_s;
            ld.pend      = 1'b1;
            ld.pend_word = cq.hold; // Stable while core waits
        end
        unique case (lq.st)
            kbl_pkg::ST_IDLE: begin
                ld.clk_oe  = 1'b0;
                ld.dat_oe  = 1'b0;
                ld.bit_idx = '0;
                ld.cnt     = lq.cnt;
                if (lq.cnt < C_SET) begin
                    ld.cnt = lq.cnt + C_ONE; // Let own drive settle
                end else if (clk_s && !dat_s) begin
                    ld.st   = kbl_pkg::ST_RX;
                    ld.cnt  = '0;
                    ld.ferr = 1'b0;
                end else if (clk_s && dat_s && (lq.resend || lq.pend)) begin
                    ld.st        = kbl_pkg::ST_TX;
                    ld.cnt       = '0;
                    ld.tx_resend = lq.resend;
                    ld.tx_legacy = load_w[8];
                    ld.sh        = {odd_par(load_w[7:0]), load_w[7:0]};
                end
            end
            kbl_pkg::ST_TX: begin
                ld.gap = chk_win ? '0 : lq.gap + GW'(1);
                if (lq.cnt == '0) begin
                    if (lq.bit_idx == '0) begin
                        ld.dat_oe = ~lq.tx_legacy;
                    end else if (lq.bit_idx <= kbl_pkg::PAR_IDX) begin
                        ld.dat_oe = ~lq.sh[lq.bit_idx - kbl_pkg::DAT_LO];
                    end else begin
                        ld.dat_oe = 1'b0;
                    end
                end
                if (chk_win && !clk_s && lq.bit_idx <= kbl_pkg::PAR_IDX) begin
                    ld.st     = kbl_pkg::ST_IDLE;
                    ld.cnt    = '0;
                    ld.clk_oe = 1'b0;
                    ld.dat_oe = 1'b0; // Byte stays pending
                end else if (bit_end) begin
                    if (lq.bit_idx == last_idx) begin
                        ld.st     = kbl_pkg::ST_IDLE;
                        ld.dat_oe = 1'b0;
                        if (lq.tx_resend) begin
                            ld.resend = 1'b0;
                        end else begin
                            ld.pend    = 1'b0;
                            ld.ack_tgl = ~lq.ack_tgl;
                        end
                    end else begin
                        ld.bit_idx = lq.bit_idx + 4'h1;
                    end
                end
            end
            kbl_pkg::ST_RX: begin
                ld.dat_oe = 1'b0;
                if (bit_end) begin
                    ld.bit_idx = lq.bit_idx + 4'h1;
                    if (lq.bit_idx >= kbl_pkg::DAT_LO
                        && lq.bit_idx <= kbl_pkg::PAR_IDX) begin
                        ld.sh[lq.bit_idx - kbl_pkg::DAT_LO] = dat_s;
                    end else if (lq.bit_idx == kbl_pkg::STOP_IDX) begin
                        if (dat_s) begin
                            ld.st     = kbl_pkg::ST_ACK;
                            ld.dat_oe = 1'b1;
                        end else begin
                            ld.st = kbl_pkg::ST_FERR;
                        end
                    end
                end
            end
            kbl_pkg::ST_FERR: begin
                ld.dat_oe = 1'b0;
                if (bit_end && dat_s) begin
                    ld.st     = kbl_pkg::ST_ACK;
                    ld.ferr   = 1'b1;
                    ld.dat_oe = 1'b1;
                end
            end
            kbl_pkg::ST_ACK: begin
                ld.dat_oe = 1'b1;
                if (bit_end) begin
                    ld.st     = kbl_pkg::ST_IDLE;
                    ld.dat_oe = 1'b0;
                    ld.clk_oe = 1'b0;
                    if (lq.ferr || !(^lq.sh)) begin
                        ld.resend = 1'b1;
                    end else begin
                        ld.rx_byte = lq.sh[7:0];
                        ld.rx_tgl  = ~lq.rx_tgl;
                    end
                end
            end
            default: begin
                ld.st     = kbl_pkg::ST_IDLE;
                ld.cnt    = '0;
                ld.clk_oe = 1'b0;
                ld.dat_oe = 1'b0;
            end
        endcase
    end

    // Link register
    always_ff @(posedge i_link_clk) begin
        if (link_rst) begin
            lq <= '0;
        end else begin
            lq <= ld;
        end
    end

    // Outputs
    assign o_tx_ready  = cq.ready;
    assign o_rx_valid  = cq.rx_valid;
    assign o_rx_data   = cq.rx_data;
    assign o_kclk_out  = lq.line_lo;
    assign o_kclk_oe   = lq.clk_oe;
    assign o_kdata_out = lq.line_lo;
    assign o_kdata_oe  = lq.dat_oe;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_link_clk); endclocking
    default disable iff (link_rst);

    property p_clk_owner;
        lq.clk_oe |-> lq.st != kbl_pkg::ST_IDLE;
    endproperty
    a_clk_owner: assert property (p_clk_owner)
        else $error("clock driven outside a sequence");

    property p_open_drain;
        (lq.clk_oe || lq.dat_oe) |-> !o_kclk_out && !o_kdata_out;
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("line driven high");

    property p_start_low;
        (lq.st == kbl_pkg::ST_TX && lq.bit_idx == '0 && lq.cnt == C_Q1
         && !lq.tx_legacy) |-> lq.dat_oe;
    endproperty
    a_start_low: assert property (p_start_low)
        else $error("start bit not low");

    property p_odd_parity;
        (lq.st == kbl_pkg::ST_TX && lq.bit_idx == kbl_pkg::PAR_IDX
         && lq.cnt == C_Q1) |-> (lq.dat_oe == ^lq.sh[7:0]);
    endproperty
    a_odd_parity: assert property (p_odd_parity)
        else $error("parity bit wrong");

    property p_legacy_start;
        (lq.st == kbl_pkg::ST_TX && lq.bit_idx == '0 && lq.cnt == C_Q1
         && lq.tx_legacy) |-> !lq.dat_oe;
    endproperty
    a_legacy_start: assert property (p_legacy_start)
        else $error("legacy start bit not high");

    property p_start_idle;
        (lq.st == kbl_pkg::ST_TX && $past(lq.st) == kbl_pkg::ST_IDLE)
        |-> $past(clk_s && dat_s);
    endproperty
    a_start_idle: assert property (p_start_idle)
        else $error("send started on busy lines");

    property p_data_stable;
        (lq.st == kbl_pkg::ST_TX && $past(lq.st) == kbl_pkg::ST_TX
         && $changed(lq.dat_oe)) |-> lq.cnt == C_ONE;
    endproperty
    a_data_stable: assert property (p_data_stable)
        else $error("data moved inside a bit");

    property p_chk_gap;
        lq.st == kbl_pkg::ST_TX |-> lq.gap < GW'(CONT_CHK_CYC);
    endproperty
    a_chk_gap: assert property (p_chk_gap)
        else $error("clock check gap too long");

    property p_abort;
        (lq.st == kbl_pkg::ST_TX && chk_win && !clk_s
         && lq.bit_idx <= kbl_pkg::PAR_IDX)
        |=> (lq.st == kbl_pkg::ST_IDLE && !lq.clk_oe && !lq.dat_oe);
    endproperty
    a_abort: assert property (p_abort)
        else $error("contention not aborted");

    property p_ack_low;
        lq.st == kbl_pkg::ST_ACK |-> lq.dat_oe;
    endproperty
    a_ack_low: assert property (p_ack_low)
        else $error("acknowledge bit not low");

    property p_ferr_free;
        lq.st == kbl_pkg::ST_FERR |-> !lq.dat_oe ##1 1'b1;
    endproperty
    a_ferr_free: assert property (p_ferr_free)
        else $error("data driven during framing wait");

    // Main scenarios
    c_tx_done: cover property (lq.st == kbl_pkg::ST_TX && bit_end
                               && lq.bit_idx == kbl_pkg::STOP_IDX);
    c_rx_ack: cover property (lq.st == kbl_pkg::ST_ACK ##1
                              lq.st == kbl_pkg::ST_IDLE);
    c_abort: cover property (lq.st == kbl_pkg::ST_TX && chk_win && !clk_s);
    c_ferr: cover property (lq.st == kbl_pkg::ST_FERR);

endmodule : kbl_link

// ==== bench/kbl_host_model.sv ====
// Host-side partner model of the keyboard serial link
`timescale 1ns/1ns
module kbl_host_model (
    // Resolved lines
    input  wire logic i_kclk,
    input  wire logic i_kdata,
    // Host pull-downs
    output logic      o_kclk_oe,
    output logic      o_kdata_oe
);
    // ------------------------------------------------------------------
    // Receive side
    // ------------------------------------------------------------------
    logic [10:0] rx_bits  = '0; // Bits seen, newest at the top
    int          rx_cnt   = 0;  // Clock falls seen
    int          hold_err = 0;  // Data moved across a low phase
    logic        sending  = 0;  // Host owns the exchange
    logic        retry    = 0;  // Last byte must go again
    logic        retry_op = 0;  // Opcode before it must go again too
    logic [7:0]  last_byte = '0; // Byte sent most recently
    logic [7:0]  prev_byte = '0; // Byte sent before that

    // Lines released at start
    initial o_kclk_oe = 1'b0;
    initial o_kdata_oe = 1'b0;

    // Sample keyboard data at each clock fall
    always @(negedge i_kclk) begin
        if (!sending) begin
            rx_bits = {i_kdata, rx_bits[10:1]};
            rx_cnt  = rx_cnt + 1;
            // Judge the first complete reply frame after a clear
            if (rx_cnt == 11) begin
                retry    = rx_bits[8:1] == kbl_pkg::RESEND_BYTE
                           || !(^rx_bits[9:1]);
                retry_op = retry && (prev_byte == 8'hF3
                           || prev_byte == 8'hF0
                           || prev_byte == 8'hED);
            end
        end
    end

    // Data must still match at the following rise
    always @(posedge i_kclk) begin
        if (!sending && rx_cnt > 0 && i_kdata !== rx_bits[10])
            hold_err = hold_err + 1;
    end

    // ------------------------------------------------------------------
    // Host actions
    // ------------------------------------------------------------------
    // Forget what was seen so far
    task automatic clear;
        rx_bits  = '0;
        rx_cnt   = 0;
        hold_err = 0;
        retry    = 0;
        retry_op = 0;
    endtask : clear

    // End an inhibit, keyboard may send again
    task automatic release_clk;
        o_kclk_oe = 1'b0;
        #1;
        clear();
    endtask : release_clk

    // Request to send, shift parity and data, check the acknowledge
    task automatic send_byte(input logic [8:0] pd, input logic inh,
                             output logic ack);
        int n;
        sending   = 1'b1;
        prev_byte = last_byte;
        last_byte = pd[7:0];
        o_kclk_oe = 1'b1;
        #61000;
        o_kdata_oe = 1'b1;
        #1000;
        o_kclk_oe = 1'b0;
        @(negedge i_kclk);
        for (n = 0; n < 9; n++) begin
            @(negedge i_kclk);
            o_kdata_oe = ~pd[n];
        end
        @(negedge i_kclk);
        o_kdata_oe = 1'b0;
        @(negedge i_kclk);
        ack = (i_kdata === 1'b0);
        @(posedge i_kclk);
        o_kclk_oe = inh;
        sending   = 1'b0;
    endtask : send_byte
endmodule : kbl_host_model

// ==== bench/testbench.sv ====
// Self-checking bench of the keyboard-side serial link
`timescale 1ns/1ns
module testbench;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic       ref_clk;
    logic       reset;
    logic       link_clk;
    logic       tx_valid;
    logic [7:0] tx_data;
    logic       legacy;
    logic       tx_ready;
    logic       rx_valid;
    logic [7:0] rx_data;
    logic       kclk;
    logic       kdata;
    logic       kclk_out;
    logic       kclk_oe;
    logic       kdata_out;
    logic       kdata_oe;
    logic       h_clk_oe;
    logic       h_data_oe;
    int         fail_count   = 0;
    int         total_checks = 0;
    int         rx_pulses    = 0;

    // Open-collector lines with pull-ups
    assign kclk  = !((kclk_oe === 1'b1 && kclk_out == 1'b0) || h_clk_oe);
    assign kdata = !((kdata_oe === 1'b1 && kdata_out == 1'b0) || h_data_oe);

    // Core and link clocks, unrelated phases
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    initial begin
        link_clk = 1'b0;
        #7;
        forever #80 link_clk = ~link_clk;
    end

    // Count received-byte pulses
    always @(posedge ref_clk) begin
        if (rx_valid === 1'b1)
            rx_pulses <= rx_pulses + 1;
    end

    kbl_link #(.QTR_CYC(6), .CONT_CHK_CYC(64)) i_kbl_link (
        .i_ref_clk(ref_clk), .i_reset(reset), .i_link_clk(link_clk),
        .i_tx_valid(tx_valid), .i_tx_data(tx_data), .i_legacy_mode(legacy),
        .o_tx_ready(tx_ready), .o_rx_valid(rx_valid), .o_rx_data(rx_data),
        .i_kclk_in(kclk), .o_kclk_out(kclk_out), .o_kclk_oe(kclk_oe),
        .i_kdata_in(kdata), .o_kdata_out(kdata_out), .o_kdata_oe(kdata_oe)
    );

    kbl_host_model i_kbl_host_model (
        .i_kclk(kclk), .i_kdata(kdata),
        .o_kclk_oe(h_clk_oe), .o_kdata_oe(h_data_oe)
    );

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic report_and_stop;
        if (fail_count == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : report_and_stop

    task automatic check(input logic [10:0] seen, input logic [10:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t ns: got %h expected %h",
                     $time, seen, exp);
        end
    endtask : check

    // Normal frame: stop, odd parity, data, start
    function automatic logic [10:0] frame(input logic [7:0] d);
        return {1'b1, ~^d, d, 1'b0};
    endfunction : frame

    // Bounded wait: 0 bits seen, 1 byte pulses, 2 send ready
    task automatic wait_for(input int sel, input int tgt);
        int n;
        int v;
        for (n = 0; n < 40000; n++) begin
            v = (sel == 0) ? i_kbl_host_model.rx_cnt :
                (sel == 1) ? rx_pulses : int'(tx_ready === 1'b1);
            if (v >= tgt)
                return;
            @(negedge ref_clk);
        end
        fail_count++;
        report_and_stop;
    endtask : wait_for

    // Offer one byte, taken while ready is high
    task automatic offer(input logic [7:0] d, input logic leg);
        @(negedge ref_clk);
        tx_valid = 1'b1;
        tx_data  = d;
        legacy   = leg;
        @(negedge ref_clk);
        tx_valid = 1'b0;
        check(11'(tx_ready), 11'h000);
    endtask : offer

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    // Nine-bit frame with high start, no parity or stop
    task automatic legacy_frame;
        i_kbl_host_model.clear();
        offer(8'h3C, 1'b1);
        wait_for(2, 1);
        check(11'(i_kbl_host_model.rx_cnt), 11'h009);
        check({i_kbl_host_model.rx_bits[10:2], 2'b00}, 11'h1E4);
        check(11'(i_kbl_host_model.hold_err), 11'h000);
    endtask : legacy_frame

    // Host overrides a frame, sends a byte, inhibits, then releases
    task automatic override_and_inhibit;
        logic ack;
        i_kbl_host_model.clear();
        offer(8'h96, 1'b0);
        wait_for(0, 3);
        fork
            i_kbl_host_model.send_byte({~^8'h5A, 8'h5A}, 1'b1, ack);
            begin
                #10000;
                check({9'h000, kclk_oe, kdata_oe}, 11'h000);
            end
        join
        check(11'(ack), 11'h001);
        wait_for(1, 1);
        check(11'(rx_data), 11'h05A);
        i_kbl_host_model.clear();
        #10000;
        check(11'(i_kbl_host_model.rx_cnt), 11'h000);
        check(11'(tx_ready), 11'h000);
        i_kbl_host_model.release_clk();
        wait_for(2, 1);
        check(i_kbl_host_model.rx_bits, frame(8'h96));
        check(11'(i_kbl_host_model.rx_cnt), 11'h00B);
        check(11'(i_kbl_host_model.hold_err), 11'h000);
        check(11'(i_kbl_host_model.retry), 11'h000);
    endtask : override_and_inhibit

    // Host byte with even parity draws a resend request
    task automatic bad_parity;
        logic ack;
        i_kbl_host_model.send_byte({^8'hC3, 8'hC3}, 1'b0, ack);
        check(11'(ack), 11'h001);
        i_kbl_host_model.clear();
        wait_for(0, 11);
        repeat (300) @(negedge ref_clk);
        check(i_kbl_host_model.rx_bits, frame(kbl_pkg::RESEND_BYTE));
        check(11'(rx_pulses), 11'h001);
        check(11'(rx_data), 11'h05A);
        check(11'(tx_ready), 11'h001);
        check(11'(i_kbl_host_model.retry), 11'h001);
        check(11'(i_kbl_host_model.retry_op), 11'h000);
    endtask : bad_parity

    // ------------------------------------------------------------------
    // Main sequence and hang guard
    // ------------------------------------------------------------------
    initial begin
        reset    = 1'b1;
        tx_valid = 1'b0;
        tx_data  = 8'h00;
        legacy   = 1'b0;
        repeat (3) @(negedge ref_clk);
        reset = 1'b0;
        // Link side leaves reset only after the stretched hold
        repeat (1600) @(negedge ref_clk);
        legacy_frame();
        override_and_inhibit();
        bad_parity();
        report_and_stop();
    end

    initial begin
        #420000;
        fail_count++;
        report_and_stop();
    end
endmodule : testbench
